// ==== accel_bank_checker.sv ====
// Assertions on the bank's request port and settings outputs.
// Assumes one clock and byte strobes spaced by an idle cycle.
module accel_bank_checker
  import accel_regs_pkg::*;
(
  // Clock and reset
  input wire logic              sys_clk,
  input wire logic              reset_n,
  // Requests
  input wire logic              xfer_start,
  input wire logic [ADDR_W-1:0] xfer_addr,
  input wire logic              byte_wr,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic              byte_rd,
  // Answers
  input wire logic [DATA_W-1:0] rd_data,
  input wire logic              rd_valid,
  input wire logic              wr_refused,
  input wire logic [ADDR_W-1:0] cur_addr,
  // Engine side
  input wire engine_status_t    engine_status,
  input wire engine_cfg_t       engine_cfg
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // Address the current byte lands on
  wire [5:0] eff  = xfer_start ? xfer_addr : cur_addr;
  wire       wake = engine_status.mode_queue[2:0] == MODE_CODE_CONT_WAKE;
  wire       rsvd = eff inside {[6'h0A:6'h0C], 6'h19, 6'h1B, [6'h1D:6'h1F], 6'h23,
                                [6'h25:6'h27], [6'h33:6'h3F]};
  wire       ro   = eff <= 6'h09 || eff inside {6'h17, 6'h18};

  a_read_answer: assert property (byte_rd |=> rd_valid) else $error("read unanswered");
  a_start_addr: assert property (xfer_start && (byte_wr || byte_rd)
    |=> cur_addr == 6'($past(xfer_addr) + 1)) else $error("start address");
  a_burst_step: assert property (!xfer_start && (byte_wr || byte_rd)
    |=> cur_addr == 6'($past(cur_addr) + 1)) else $error("burst step");
  a_ro_refused: assert property (byte_wr && ro |=> wr_refused) else $error("ro write");
  a_refuse_cause: assert property (wr_refused |-> $past(byte_wr)) else $error("stray refuse");
  a_rsvd_refused: assert property (byte_wr && rsvd |=> wr_refused) else $error("rsvd write");
  a_rsvd_zero: assert property (byte_rd && rsvd |=> rd_data == 8'h00) else $error("rsvd read");
  a_wo_zero: assert property (byte_rd && eff == 6'h0F |=> rd_data == 8'h00) else $error("wo read");
  a_rw_store: assert property (byte_wr && eff == 6'h11 && !wake && !$past(wake)
    |=> engine_cfg.wake_rate == $past(wr_data)) else $error("rw store");
  a_wake_block: assert property (byte_wr && eff == 6'h11 && wake && $past(wake)
    |=> wr_refused && $stable(engine_cfg.wake_rate)) else $error("wake block");
  a_mode_open: assert property (byte_wr && eff == 6'h10
    |=> !wr_refused && engine_cfg.operating_mode == $past(wr_data)) else $error("mode");
endmodule

bind accel_register_bank accel_bank_checker chk_u (
  .sys_clk(sys_clk), .reset_n(reset_n), .xfer_start(xfer_start), .xfer_addr(xfer_addr),
  .byte_wr(byte_wr), .wr_data(wr_data), .byte_rd(byte_rd), .rd_data(rd_data),
  .rd_valid(rd_valid), .wr_refused(wr_refused), .cur_addr(cur_addr),
  .engine_status(engine_status), .engine_cfg(engine_cfg));

// ==== accel_register_bank.sv ====
// Byte-wide register bank of the three-axis motion sensor.
// Assumes the serial front end strobes bytes on sys_clk, one request per two cycles at most.

// Overview of operation
// - Byte registers let the serial host configure every function and observe status.
// - Bit zero of each byte is the least significant, bit seven the most.
// - Read-only registers return live contents; host writes leave them unchanged.
// - Read-write registers store each host write and return it on later reads.
// - Write-only registers accept writes; read-back carries no meaning, returns zero.
// - Shadow threshold storage is reached only through one shared portal address.
// - Sixty-four locations, each access carries a six-bit address from the host.
// - Each extra byte in a transfer steps to the next consecutive address.
// - In continuous wake, only the operating mode control register accepts writes.
module accel_register_bank
  import accel_regs_pkg::*;
#(
  parameter logic [7:0] IDENTITY_CODE  = 8'h5A,  // Arbitrary value, no meaning
  parameter logic [7:0] TRIM_RESET     = RST_TRIM,
  parameter logic [2:0] WAKE_MODE_CODE = MODE_CODE_CONT_WAKE,
  parameter int         SHADOW_DEPTH   = SHADOW_DEPTH_DEF
) (
  // Clock and reset
  input  wire logic                sys_clk,
  input  wire logic                reset_n,
  // Serial front end requests
  input  wire logic                xfer_start,
  input  wire logic [ADDR_W-1:0]   xfer_addr,
  input  wire logic                byte_wr,
  input  wire logic [DATA_W-1:0]   wr_data,
  input  wire logic                byte_rd,
  // Serial front end answers
  output logic      [DATA_W-1:0]   rd_data,
  output logic                     rd_valid,
  output logic                     wr_refused,
  output logic      [ADDR_W-1:0]   cur_addr,
  // Address strap pin
  input  wire logic                addr_pin,
  // Sampling engine
  input  wire engine_status_t      engine_status,
  output engine_cfg_t              engine_cfg
);

  localparam int SHADOW_AW = $clog2(SHADOW_DEPTH);

  // Threshold select field holds three bits, so no more than eight cells
  if (SHADOW_DEPTH < 2 || SHADOW_DEPTH > 8 || (1 << SHADOW_AW) != SHADOW_DEPTH) begin : g_chk
    $error("SHADOW_DEPTH must be a power of two from 2 to 8");
  end

  // Access class of each location
  function automatic reg_class_t reg_class(input logic [5:0] loc);
    reg_class_t c;
    c = CLASS_RESERVED;
    case (loc)
      OFF_ADDRESS_PIN_STATUS:        c = CLASS_READ_ONLY;
      OFF_EXTENDED_CONDITION_STATUS: c = CLASS_READ_ONLY;
      OFF_X_SAMPLE_LOW:              c = CLASS_READ_ONLY;
      OFF_X_SAMPLE_HIGH:             c = CLASS_READ_ONLY;
      OFF_Y_SAMPLE_LOW:              c = CLASS_READ_ONLY;
      OFF_Y_SAMPLE_HIGH:             c = CLASS_READ_ONLY;
      OFF_Z_SAMPLE_LOW:              c = CLASS_READ_ONLY;
      OFF_Z_SAMPLE_HIGH:             c = CLASS_READ_ONLY;
      OFF_MODE_QUEUE_STATUS:         c = CLASS_READ_ONLY;
      OFF_INTERRUPT_EVENT_STATUS:    c = CLASS_READ_ONLY;
      OFF_INTERRUPT_ENABLE_CTRL:     c = CLASS_READ_ONLY;
      OFF_PART_IDENTITY:             c = CLASS_READ_ONLY;
      OFF_INTERFACE_FEATURE_CFG:     c = CLASS_READ_WRITE;
      OFF_TRIGGER_QUEUE_FEATURE_CFG: c = CLASS_READ_WRITE;
      OFF_OPERATING_MODE_CTRL:       c = CLASS_READ_WRITE;
      OFF_WAKE_RATE_SELECT:          c = CLASS_READ_WRITE;
      OFF_SNIFF_RATE_CTRL:           c = CLASS_READ_WRITE;
      OFF_SNIFF_CONFIG_CTRL:         c = CLASS_READ_WRITE;
      OFF_RANGE_RESOLUTION_CTRL:     c = CLASS_READ_WRITE;
      OFF_SAMPLE_QUEUE_CTRL:         c = CLASS_READ_WRITE;
      OFF_INIT_WORD_THREE:           c = CLASS_READ_WRITE;
      OFF_POWER_MODE_CTRL:           c = CLASS_READ_WRITE;
      OFF_X_DRIVE_MOTION:            c = CLASS_READ_WRITE;
      OFF_Y_DRIVE_MOTION:            c = CLASS_READ_WRITE;
      OFF_Z_DRIVE_MOTION:            c = CLASS_READ_WRITE;
      OFF_SOFT_RESET_CTRL:           c = CLASS_READ_WRITE;
      OFF_INIT_WORD_TWO:             c = CLASS_READ_WRITE;
      OFF_TRIGGER_COUNT:             c = CLASS_READ_WRITE;
      OFF_X_OFFSET_LOW:              c = CLASS_READ_WRITE;
      OFF_X_OFFSET_HIGH:             c = CLASS_READ_WRITE;
      OFF_Y_OFFSET_LOW:              c = CLASS_READ_WRITE;
      OFF_Y_OFFSET_HIGH:             c = CLASS_READ_WRITE;
      OFF_Z_OFFSET_LOW:              c = CLASS_READ_WRITE;
      OFF_Z_OFFSET_HIGH:             c = CLASS_READ_WRITE;
      OFF_X_GAIN_TRIM:               c = CLASS_READ_WRITE;
      OFF_Y_GAIN_TRIM:               c = CLASS_READ_WRITE;
      OFF_Z_GAIN_TRIM:               c = CLASS_READ_WRITE;
      OFF_INIT_WORD_ONE:             c = CLASS_WRITE_ONLY;
      OFF_SNIFF_THRESHOLD_PORTAL:    c = CLASS_SHADOW_PORT;
      default:                       c = CLASS_RESERVED;
    endcase
    return c;
  endfunction

  // Value loaded at reset
  function automatic logic [7:0] reset_value(input logic [5:0] loc);
    logic [7:0] v;
    v = RST_DEFAULT;
    case (loc)
      OFF_EXTENDED_CONDITION_STATUS: v = RST_EXTENDED_CONDITION_STATUS;
      OFF_X_OFFSET_LOW:              v = TRIM_RESET;
      OFF_X_OFFSET_HIGH:             v = TRIM_RESET;
      OFF_Y_OFFSET_LOW:              v = TRIM_RESET;
      OFF_Y_OFFSET_HIGH:             v = TRIM_RESET;
      OFF_Z_OFFSET_LOW:              v = TRIM_RESET;
      OFF_Z_OFFSET_HIGH:             v = TRIM_RESET;
      OFF_X_GAIN_TRIM:               v = TRIM_RESET;
      OFF_Y_GAIN_TRIM:               v = TRIM_RESET;
      OFF_Z_GAIN_TRIM:               v = TRIM_RESET;
      default:                       v = RST_DEFAULT;
    endcase
    return v;
  endfunction

  // Storage and live sources, one byte per location
  logic [DATA_W-1:0]    bank       [REG_COUNT];
  logic [DATA_W-1:0]    status_src [REG_COUNT];

  // Strap capture
  logic                 pin_meta;
  logic                 pin_sync;
  logic [1:0]           strap_age;
  logic                 strap_done;
  logic                 strap_level;

  // Address and access decode
  logic [ADDR_W-1:0]    eff_addr;
  logic [ADDR_W-1:0]    next_addr;
  reg_class_t           acc_class;
  logic                 cont_wake;
  logic                 wr_allowed;
  logic                 wr_store;
  logic                 wr_portal;
  logic                 byte_op;
  logic [DATA_W-1:0]    read_byte;
  logic [SHADOW_AW-1:0] shadow_sel;
  logic [DATA_W-1:0]    shadow_rd;

  // Strap pin crosses in through two flops, then is caught once after release
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
    end else begin
      pin_meta <= addr_pin;
      pin_sync <= pin_meta;
    end
  end

  // Sync flops still hold reset zeros for two edges; wait them out
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      strap_age <= 2'b00;
    end else begin
      strap_age <= {strap_age[0], 1'b1};
    end
  end

  // Held until the next reset_n assertion; later pin activity is serial data
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      strap_done  <= 1'b0;
      strap_level <= 1'b0;
    end else if (strap_age[1] && !strap_done) begin
      strap_done  <= 1'b1;
      strap_level <= pin_sync;
    end
  end

  // Live bytes, little-endian per axis, bit 0 is the LSB
  always_comb begin
    for (int k = 0; k < REG_COUNT; k++) begin
      status_src[k] = 8'h00;
    end
    status_src[OFF_ADDRESS_PIN_STATUS][ADDR_PIN_BIT] = strap_level;
    status_src[OFF_EXTENDED_CONDITION_STATUS]        = engine_status.condition;
    status_src[OFF_X_SAMPLE_LOW]                     = engine_status.x_sample[7:0];
    status_src[OFF_X_SAMPLE_HIGH]                    = engine_status.x_sample[15:8];
    status_src[OFF_Y_SAMPLE_LOW]                     = engine_status.y_sample[7:0];
    status_src[OFF_Y_SAMPLE_HIGH]                    = engine_status.y_sample[15:8];
    status_src[OFF_Z_SAMPLE_LOW]                     = engine_status.z_sample[7:0];
    status_src[OFF_Z_SAMPLE_HIGH]                    = engine_status.z_sample[15:8];
    status_src[OFF_MODE_QUEUE_STATUS]                = engine_status.mode_queue;
    status_src[OFF_INTERRUPT_EVENT_STATUS]           = engine_status.event_flags;
    status_src[OFF_INTERRUPT_ENABLE_CTRL]            = engine_status.interrupt_enable;
    status_src[OFF_PART_IDENTITY]                    = IDENTITY_CODE;
  end

  // A byte arriving with the start strobe uses the fresh address
  assign eff_addr   = xfer_start ? xfer_addr : cur_addr;
  assign acc_class  = reg_class(eff_addr);
  assign byte_op    = byte_wr | byte_rd;
  // Six-bit counter wraps from the top location back to zero
  assign next_addr  = eff_addr + 6'h01;

  // Mode field reflects the engine's actual mode, not the requested one
  assign cont_wake  = bank[OFF_MODE_QUEUE_STATUS][MODE_FIELD_MSB:MODE_FIELD_LSB]
                      == WAKE_MODE_CODE;
  assign wr_allowed = !cont_wake || (eff_addr == OFF_OPERATING_MODE_CTRL);
  assign wr_store   = byte_wr && wr_allowed &&
                      (acc_class == CLASS_READ_WRITE || acc_class == CLASS_WRITE_ONLY);
  assign wr_portal  = byte_wr && wr_allowed && (acc_class == CLASS_SHADOW_PORT);

  // Portal cell picked by the low bits of the sniff configuration byte
  assign shadow_sel = bank[OFF_SNIFF_CONFIG_CTRL][SHADOW_AW-1:0];

  // Write-only and reserved bytes read as zero
  assign read_byte  = (acc_class == CLASS_SHADOW_PORT) ? shadow_rd :
                      (acc_class == CLASS_WRITE_ONLY)  ? 8'h00 :
                      bank[eff_addr];

  for (genvar i = 0; i < REG_COUNT; i++) begin : g_loc
    localparam logic [5:0] LOC = 6'(i);
    localparam reg_class_t CLS = reg_class(LOC);
    if (CLS == CLASS_READ_ONLY) begin : g_ro
      // Host writes never reach these; they reload from status_src every cycle
      always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          bank[i] <= reset_value(LOC);
        end else begin
          bank[i] <= status_src[i];
        end
      end
    end else if (CLS == CLASS_READ_WRITE || CLS == CLASS_WRITE_ONLY) begin : g_rw
      always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          bank[i] <= reset_value(LOC);
        end else if (wr_store && eff_addr == LOC) begin
          bank[i] <= wr_data;
        end
      end
    end else begin : g_none
      // Reserved and portal addresses hold nothing here
      assign bank[i] = 8'h00;
    end
  end

  shadow_store #(
    .WIDTH   (DATA_W),
    .DEPTH   (SHADOW_DEPTH),
    .AW      (SHADOW_AW)
  ) u_shadow (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .wr_en   (wr_portal),
    .wr_addr (shadow_sel),
    .wr_data (wr_data),
    .rd_addr (shadow_sel),
    .rd_data (shadow_rd)
  );

  // Address pointer and answers
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cur_addr <= '0;
    end else if (byte_op) begin
      cur_addr <= next_addr;
    end else if (xfer_start) begin
      cur_addr <= xfer_addr;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data    <= '0;
      rd_valid   <= 1'b0;
      wr_refused <= 1'b0;
    end else begin
      rd_valid   <= byte_rd;
      wr_refused <= byte_wr && !(wr_store || wr_portal);
      if (byte_rd) begin
        rd_data <= read_byte;
      end
    end
  end

  // Settings fan out straight from the register flops
  assign engine_cfg.interface_feature     = bank[OFF_INTERFACE_FEATURE_CFG];
  assign engine_cfg.trigger_queue_feature = bank[OFF_TRIGGER_QUEUE_FEATURE_CFG];
  assign engine_cfg.init_one              = bank[OFF_INIT_WORD_ONE];
  assign engine_cfg.operating_mode        = bank[OFF_OPERATING_MODE_CTRL];
  assign engine_cfg.wake_rate             = bank[OFF_WAKE_RATE_SELECT];
  assign engine_cfg.sniff_rate            = bank[OFF_SNIFF_RATE_CTRL];
  assign engine_cfg.sniff_config          = bank[OFF_SNIFF_CONFIG_CTRL];
  assign engine_cfg.range_resolution      = bank[OFF_RANGE_RESOLUTION_CTRL];
  assign engine_cfg.sample_queue          = bank[OFF_SAMPLE_QUEUE_CTRL];
  assign engine_cfg.init_three            = bank[OFF_INIT_WORD_THREE];
  assign engine_cfg.power_mode            = bank[OFF_POWER_MODE_CTRL];
  assign engine_cfg.drive_motion          = {bank[OFF_Z_DRIVE_MOTION],
                                             bank[OFF_Y_DRIVE_MOTION],
                                             bank[OFF_X_DRIVE_MOTION]};
  assign engine_cfg.soft_reset            = bank[OFF_SOFT_RESET_CTRL];
  assign engine_cfg.init_two              = bank[OFF_INIT_WORD_TWO];
  assign engine_cfg.trigger_count         = bank[OFF_TRIGGER_COUNT];
  assign engine_cfg.offsets               = {bank[OFF_Z_OFFSET_HIGH],
                                             bank[OFF_Z_OFFSET_LOW],
                                             bank[OFF_Y_OFFSET_HIGH],
                                             bank[OFF_Y_OFFSET_LOW],
                                             bank[OFF_X_OFFSET_HIGH],
                                             bank[OFF_X_OFFSET_LOW]};
  assign engine_cfg.gains                 = {bank[OFF_Z_GAIN_TRIM],
                                             bank[OFF_Y_GAIN_TRIM],
                                             bank[OFF_X_GAIN_TRIM]};

endmodule

// ==== accel_regs_pkg.sv ====
// Register map constants and carrier types for the motion sensor register bank.
// Assumes one device clock; the serial front end decodes frames on the same clock.
package accel_regs_pkg;

  // Map geometry
  localparam int          REG_COUNT       = 64;
  localparam int          ADDR_W          = 6;
  localparam int          DATA_W          = 8;

  // Offsets
  localparam logic [5:0]  OFF_ADDRESS_PIN_STATUS        = 6'h00;
  localparam logic [5:0]  OFF_EXTENDED_CONDITION_STATUS = 6'h01;
  localparam logic [5:0]  OFF_X_SAMPLE_LOW              = 6'h02;
  localparam logic [5:0]  OFF_X_SAMPLE_HIGH             = 6'h03;
  localparam logic [5:0]  OFF_Y_SAMPLE_LOW              = 6'h04;
  localparam logic [5:0]  OFF_Y_SAMPLE_HIGH             = 6'h05;
  localparam logic [5:0]  OFF_Z_SAMPLE_LOW              = 6'h06;
  localparam logic [5:0]  OFF_Z_SAMPLE_HIGH             = 6'h07;
  localparam logic [5:0]  OFF_MODE_QUEUE_STATUS         = 6'h08;
  localparam logic [5:0]  OFF_INTERRUPT_EVENT_STATUS    = 6'h09;
  localparam logic [5:0]  OFF_INTERFACE_FEATURE_CFG     = 6'h0D;
  localparam logic [5:0]  OFF_TRIGGER_QUEUE_FEATURE_CFG = 6'h0E;
  localparam logic [5:0]  OFF_INIT_WORD_ONE             = 6'h0F;
  localparam logic [5:0]  OFF_OPERATING_MODE_CTRL       = 6'h10;
  localparam logic [5:0]  OFF_WAKE_RATE_SELECT          = 6'h11;
  localparam logic [5:0]  OFF_SNIFF_RATE_CTRL           = 6'h12;
  localparam logic [5:0]  OFF_SNIFF_THRESHOLD_PORTAL    = 6'h13;
  localparam logic [5:0]  OFF_SNIFF_CONFIG_CTRL         = 6'h14;
  localparam logic [5:0]  OFF_RANGE_RESOLUTION_CTRL     = 6'h15;
  localparam logic [5:0]  OFF_SAMPLE_QUEUE_CTRL         = 6'h16;
  localparam logic [5:0]  OFF_INTERRUPT_ENABLE_CTRL     = 6'h17;
  localparam logic [5:0]  OFF_PART_IDENTITY             = 6'h18;
  localparam logic [5:0]  OFF_INIT_WORD_THREE           = 6'h1A;
  localparam logic [5:0]  OFF_POWER_MODE_CTRL           = 6'h1C;
  localparam logic [5:0]  OFF_X_DRIVE_MOTION            = 6'h20;
  localparam logic [5:0]  OFF_Y_DRIVE_MOTION            = 6'h21;
  localparam logic [5:0]  OFF_Z_DRIVE_MOTION            = 6'h22;
  localparam logic [5:0]  OFF_SOFT_RESET_CTRL           = 6'h24;
  localparam logic [5:0]  OFF_INIT_WORD_TWO             = 6'h28;
  localparam logic [5:0]  OFF_TRIGGER_COUNT             = 6'h29;
  localparam logic [5:0]  OFF_X_OFFSET_LOW              = 6'h2A;
  localparam logic [5:0]  OFF_X_OFFSET_HIGH             = 6'h2B;
  localparam logic [5:0]  OFF_Y_OFFSET_LOW              = 6'h2C;
  localparam logic [5:0]  OFF_Y_OFFSET_HIGH             = 6'h2D;
  localparam logic [5:0]  OFF_Z_OFFSET_LOW              = 6'h2E;
  localparam logic [5:0]  OFF_Z_OFFSET_HIGH             = 6'h2F;
  localparam logic [5:0]  OFF_X_GAIN_TRIM               = 6'h30;
  localparam logic [5:0]  OFF_Y_GAIN_TRIM               = 6'h31;
  localparam logic [5:0]  OFF_Z_GAIN_TRIM               = 6'h32;

  // Field positions
  localparam int          ADDR_PIN_BIT    = 3;
  localparam int          MODE_FIELD_LSB  = 0;
  localparam int          MODE_FIELD_MSB  = 2;

  // Values after reset, the continuous wake mode code and the default portal depth
  localparam logic [7:0]  RST_DEFAULT                   = 8'h00;
  localparam logic [7:0]  RST_EXTENDED_CONDITION_STATUS = 8'h04;
  localparam logic [7:0]  RST_TRIM                      = 8'h00;
  localparam logic [2:0]  MODE_CODE_CONT_WAKE           = 3'h5;
  localparam int          SHADOW_DEPTH_DEF              = 8;

  // Access classes
  typedef enum logic [2:0] {
    CLASS_RESERVED     = 3'b000,
    CLASS_READ_ONLY    = 3'b001,
    CLASS_READ_WRITE   = 3'b010,
    CLASS_WRITE_ONLY   = 3'b011,
    CLASS_SHADOW_PORT  = 3'b100
  } reg_class_t;

  // Live state from the sampling engine
  typedef struct packed {
    logic [7:0]  condition;
    logic [15:0] x_sample;
    logic [15:0] y_sample;
    logic [15:0] z_sample;
    logic [7:0]  mode_queue;
    logic [7:0]  event_flags;
    logic [7:0]  interrupt_enable;
  } engine_status_t;

  // Settings handed to the rest of the device
  typedef struct packed {
    logic [7:0]  interface_feature;
    logic [7:0]  trigger_queue_feature;
    logic [7:0]  init_one;
    logic [7:0]  operating_mode;
    logic [7:0]  wake_rate;
    logic [7:0]  sniff_rate;
    logic [7:0]  sniff_config;
    logic [7:0]  range_resolution;
    logic [7:0]  sample_queue;
    logic [7:0]  init_three;
    logic [7:0]  power_mode;
    logic [23:0] drive_motion;
    logic [7:0]  soft_reset;
    logic [7:0]  init_two;
    logic [7:0]  trigger_count;
    logic [47:0] offsets;
    logic [23:0] gains;
  } engine_cfg_t;

endpackage

// ==== host_model.sv ====
// Behavioural serial front end that issues byte requests to the bank.
// Assumes the bank answers one cycle after each taken strobe.
module host_model
  import accel_regs_pkg::*;
(
  // Clock
  input  wire logic              sys_clk,
  // Requests
  output logic                   xfer_start,
  output logic      [ADDR_W-1:0] xfer_addr,
  output logic                   byte_wr,
  output logic      [DATA_W-1:0] wr_data,
  output logic                   byte_rd,
  // Answers
  input  wire logic [DATA_W-1:0] rd_data,
  input  wire logic              rd_valid,
  input  wire logic              wr_refused
);
  initial {xfer_start, xfer_addr, byte_wr, wr_data, byte_rd} = '0;

  // One byte op; trailing idle cycle keeps strobes apart
  task automatic op(input logic st, input logic [5:0] a, input logic wr,
                    input logic [7:0] d, output logic [7:0] q, output logic rf);
    @(negedge sys_clk);
    xfer_start = st;
    xfer_addr  = a;
    byte_wr    = wr;
    byte_rd    = !wr;
    wr_data    = d;
    @(negedge sys_clk);
    {xfer_start, byte_wr, byte_rd} = '0;
    // Released lines must not echo the last value
    xfer_addr  = ~a;
    wr_data    = ~d;
    q  = rd_valid ? rd_data : 8'hXX;
    rf = wr_refused;
    @(negedge sys_clk);
  endtask
endmodule

// ==== shadow_store.sv ====
// Small register-file memory behind the sniff threshold portal.
// Read data is registered and follows the read address one clock later.
module shadow_store #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8,
  parameter int AW    = $clog2(DEPTH)
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             reset_n,
  // Write side
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  // Read side
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] cells [DEPTH];

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int k = 0; k < DEPTH; k++) begin
        cells[k] <= '0;
      end
      rd_data <= '0;
    end else begin
      if (wr_en) begin
        cells[wr_addr] <= wr_data;
      end
      rd_data <= cells[rd_addr];
    end
  end

endmodule

// ==== tb_top.sv ====
// Self-checking bench for the motion sensor register bank.
// Assumes the host model drives all request strobes on falling edges.
module tb_top
  import accel_regs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] ID_CODE = 8'hA6;  // Arbitrary value
  logic           sys_clk = 0;
  logic           reset_n = 0;
  logic           addr_pin = 1'b1;
  logic           xfer_start, byte_wr, byte_rd, rd_valid, wr_refused, rf;
  logic [5:0]     xfer_addr, cur_addr;
  logic [7:0]     wr_data, rd_data, q;
  engine_status_t engine_status = '0;
  engine_cfg_t    engine_cfg;
  int             bad_count = 0;
  int             checked = 0;
  int             cyc = 0;
  logic [7:0]     live [10] = '{8'h08, 8'h81, 8'h34, 8'h12, 8'h78,
                                8'h56, 8'hBC, 8'h9A, 8'hF5, 8'h3C};

  always #20 sys_clk = ~sys_clk;

  accel_register_bank #(.IDENTITY_CODE(ID_CODE)) dut_u (
    .sys_clk(sys_clk), .reset_n(reset_n), .xfer_start(xfer_start), .xfer_addr(xfer_addr),
    .byte_wr(byte_wr), .wr_data(wr_data), .byte_rd(byte_rd), .rd_data(rd_data),
    .rd_valid(rd_valid), .wr_refused(wr_refused), .cur_addr(cur_addr), .addr_pin(addr_pin),
    .engine_status(engine_status), .engine_cfg(engine_cfg));
  host_model host_u (
    .sys_clk(sys_clk), .xfer_start(xfer_start), .xfer_addr(xfer_addr), .byte_wr(byte_wr),
    .wr_data(wr_data), .byte_rd(byte_rd), .rd_data(rd_data), .rd_valid(rd_valid),
    .wr_refused(wr_refused));

  function automatic reg_class_t cls(input logic [5:0] a);
    if (a <= 6'h09 || a inside {6'h17, 6'h18}) return CLASS_READ_ONLY;
    if (a == 6'h0F) return CLASS_WRITE_ONLY;
    if (a == 6'h13) return CLASS_SHADOW_PORT;
    if (a inside {[6'h0D:6'h0E], [6'h10:6'h12], [6'h14:6'h16], 6'h1A, 6'h1C,
                  [6'h20:6'h22], 6'h24, [6'h28:6'h32]}) return CLASS_READ_WRITE;
    return CLASS_RESERVED;
  endfunction
  function automatic logic [7:0] pat(input logic [5:0] a);
    return {a[1:0], a};
  endfunction
  // Engine inputs all zero here; strap pin is high
  function automatic logic [7:0] exp_rd(input logic [5:0] a, input logic wrote);
    if (cls(a) == CLASS_READ_WRITE) return wrote ? pat(a) : 8'h00;
    if (a == 6'h00) return 8'h08;
    return a == 6'h18 ? ID_CODE : 8'h00;
  endfunction

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    host_u.op(1'b1, a, 1'b1, d, q, rf);
  endtask
  task automatic rd(input logic [5:0] a);
    host_u.op(1'b1, a, 1'b0, 8'h00, q, rf);
  endtask
  task automatic complete_run();
    $display("Comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      complete_run();
    end
  end

  initial begin
    logic [5:0] a;
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk) reset_n = 1;
    // Strap capture needs three edges
    repeat (4) @(negedge sys_clk);
    for (int i = 0; i < 64; i++) begin
      a = 6'(i);
      host_u.op(i == 0, a, 1'b0, 8'h00, q, rf);
      chk("reset map", exp_rd(a, 1'b0), q);
    end
    chk("wrap", 8'h00, {2'b00, cur_addr});
    $display("Test reset_map done");
    for (int i = 0; i < 64; i++) begin
      a = 6'(i);
      host_u.op(i == 0, a, 1'b1, pat(a), q, rf);
      chk("refuse", {7'h00, cls(a) inside {CLASS_READ_ONLY, CLASS_RESERVED}}, {7'h00, rf});
    end
    for (int i = 0; i < 64; i++) begin
      a = 6'(i);
      host_u.op(i == 0, a, 1'b0, 8'h00, q, rf);
      chk("readback", exp_rd(a, 1'b1), q);
    end
    chk("cfg mode", pat(6'h10), engine_cfg.operating_mode);
    chk("cfg z drive", pat(6'h22), engine_cfg.drive_motion[23:16]);
    $display("Test burst_access done");
    wr(6'h14, 8'h03);
    wr(6'h13, 8'h5C);
    wr(6'h14, 8'h05);
    wr(6'h13, 8'hC3);
    wr(6'h14, 8'h00);
    rd(6'h13);
    chk("portal cell 0", pat(6'h13), q);
    wr(6'h14, 8'h03);
    rd(6'h13);
    chk("portal cell 3", 8'h5C, q);
    wr(6'h14, 8'h05);
    rd(6'h13);
    chk("portal cell 5", 8'hC3, q);
    $display("Test shadow_portal done");
    engine_status = '{8'h81, 16'h1234, 16'h5678, 16'h9ABC, 8'hF5, 8'h3C, 8'hC6};
    for (int i = 0; i < 10; i++) begin
      host_u.op(i == 0, 6'(i), 1'b0, 8'h00, q, rf);
      chk("status", live[i], q);
    end
    rd(6'h17);
    chk("int enable", 8'hC6, q);
    $display("Test live_status done");
    wr(6'h11, 8'h77);
    chk("wake refuse", 8'h01, {7'h00, rf});
    rd(6'h11);
    chk("wake hold", pat(6'h11), q);
    wr(6'h10, 8'h21);
    chk("mode refuse", 8'h00, {7'h00, rf});
    rd(6'h10);
    chk("mode value", 8'h21, q);
    engine_status.mode_queue = 8'h04;
    wr(6'h11, 8'h77);
    rd(6'h11);
    chk("idle write", 8'h77, q);
    $display("Test wake_lock done");
    @(negedge sys_clk) {addr_pin, reset_n} = 2'b00;
    repeat (2) @(negedge sys_clk);
    reset_n = 1'b1;
    chk("reset mode", 8'h00, engine_cfg.operating_mode);
    repeat (4) @(negedge sys_clk);
    rd(6'h00);
    chk("strap low", 8'h00, q);
    rd(6'h11);
    chk("reset rate", 8'h00, q);
    $display("Test mid_reset done");
    complete_run();
  end
endmodule
